// ### smc_core_model.sv
// Purpose: core and reset pin partner of the standby control
// Assumes: tasks are entered just after a rising edge
// Notes: reset is held long, as no warm-up follows it
`timescale 1ns/100ps
module smc_core_model (
  // clock
  input wire logic core_clk,
  // toward the standby control
  output logic haltReq,
  output logic rstn
);
  initial begin
    haltReq = 1'b0;
    rstn = 1'b0;
  end
  // one-cycle pulse, as a halt instruction gives
  task automatic halt();
    haltReq <= 1'b1;
    @(posedge core_clk);
    haltReq <= 1'b0;
  endtask
  // reset held for n cycles; caller picks n to cover oscillator start
  task automatic reset(input int n);
    rstn <= 1'b0;
    repeat (n) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
endmodule

// ### smc_pin_sync.sv
// Purpose: three-flop synchroniser for the wake pins
// Assumes: pins are asynchronous to core_clk
// Notes: a change counts only when flops two and three agree
`timescale 1ns/100ps
module smc_pin_sync
  import smc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // raw pins, active high
  input wire logic [1:0] pinRaw,
  // filtered result
  smc_wake_if.src wake
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] level;
    logic [1:0] rise;
  } smc_sync_t;
  smc_sync_t st_q, st_d;

  ////////////////////////////////////////////////////////////////////////////////
  // next state: s1 feeds s2 only, the filter looks at s2 and s3
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinRaw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 2; i++) begin
      st_d.rise[i] = 1'b0;
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
        st_d.rise[i] = st_q.s3[i] & ~st_q.level[i];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wake.level = st_q.level;
  assign wake.rise = st_q.rise;
endmodule

// ### smc_pkg.sv
// Purpose: types of the standby control
// Assumes: nothing beyond smc_regs.svh
// Notes: constants live in the header
package smc_pkg;
  // controller states
  typedef enum logic [2:0] {
    SMC_ACTIVE, SMC_ENTER, SMC_RUN_HALT, SMC_IDLE_HALT, SMC_STOP_HALT, SMC_WARMUP
  } smc_state_t;
  // standby mode field codes
  typedef enum logic [1:0] {
    SMC_MODE_RUN = 2'b00, SMC_MODE_STOP = 2'b01, SMC_MODE_IDLE = 2'b10, SMC_MODE_DC = 2'b11
  } smc_mode_t;
  // wake sources
  typedef enum logic [1:0] {
    SMC_SRC_NONE, SMC_SRC_NMI, SMC_SRC_EXTERNAL_IRQ_ZERO_PIN, SMC_SRC_OTHER
  } smc_src_t;
endpackage

// ### smc_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the standby control
// Assumes: core_clk at 40 MHz; the oscillator clock and core_clk are the same clock
// Notes: definitions only
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_WSM_OFFSET 12'h05C
`define SMC_WSM_RESET 8'h80
`define SMC_BIT_DRIVE 0
`define SMC_BIT_RESLINK 1
`define SMC_BIT_SEL_LO 2
`define SMC_BIT_SEL_HI 3
`define SMC_BIT_WARM 4
`define SMC_BIT_PER_LO 5
`define SMC_BIT_PER_HI 6
`define SMC_BIT_WDEN 7
`define SMC_ENTRY_CYCLES 2'd3
`define SMC_WARM_SHORT 18'd16384
`define SMC_WARM_LONG 18'd65536
`define SMC_NMI_LEVEL 3'h7
`endif

// ### smc_standby_ctrl.sv
// Purpose: standby mode control with APB register access
// Assumes: haltReq is a one-cycle pulse from the core; irq inputs are on core_clk
// Notes: clocks are shown as enables; real gating sits outside this block
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_standby_ctrl
  import smc_pkg::*;
#(
  parameter logic [17:0] WARM_SHORT = `SMC_WARM_SHORT,
  parameter logic [17:0] WARM_LONG = `SMC_WARM_LONG
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic haltReq,
  input wire logic irqReq,
  input wire logic [2:0] irqLevel,
  input wire logic [2:0] interruptMaskLevel,
  input wire logic [2:0] int0Level,
  // wake pins
  input wire logic nmiPin_n,
  input wire logic externalIrqZeroPin,
  // pull selection inputs
  input wire logic pullFuncSel,
  input wire logic pullFuncData,
  input wire logic pullPortBit,
  // clock enables and core control
  output logic cpuRun,
  output logic periphClkEn,
  output logic oscEn,
  output logic sysClkEn,
  // wake results
  output logic wakeService,
  output logic wakeResume,
  output smc_src_t serviceFirst,
  output smc_src_t serviceSecond,
  output logic pendValid,
  // pin control in STOP and IDLE (aleForceLow in both), pull choice at all times
  output logic pinOutEn,
  output logic pinInGateEn,
  output logic aleForceLow,
  output logic oscOutForceHigh,
  output logic pullSel
);
  typedef struct packed {
    logic [7:0] wsm;
    logic [31:0] rdata;
    logic ready;
    logic err;
    smc_state_t state;
    logic [1:0] entryCnt;
    smc_mode_t mode;
    smc_src_t pendSrc;
    logic pendValid;
    logic warmStart;
    logic cpuRun;
    logic periphClkEn;
    logic oscEn;
    logic sysClkEn;
    logic wakeService;
    logic wakeResume;
    smc_src_t first;
    smc_src_t second;
    logic pinOutEn;
    logic pinInGateEn;
    logic aleForceLow;
    logic oscOutForceHigh;
    logic pullSel;
  } smc_top_t;
  smc_top_t st_q, st_d;

  smc_wake_if wake (); // synchronised pin events
  logic warmDone; // warm-up finished pulse
  logic [1:0] pinRaw; // pins turned active high
  logic hit; // address decode
  logic nmiWake; // nmi request seen
  logic int0Wake; // external_irq_zero_pin request seen
  logic int0Unmasked; // external_irq_zero_pin level passes the mask
  smc_src_t waker; // source of the current wake-up
  logic [2:0] wakerLvl; // its priority
  logic [2:0] pendLvl; // priority of the held request

  ////////////////////////////////////////////////////////////////////////////////
  // sub blocks
  assign pinRaw = {externalIrqZeroPin, ~nmiPin_n};

  // both wake pins pass the three-flop filter before any decision
  smc_pin_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinRaw(pinRaw),
    .wake(wake)
  );

  // warm-up timer; only a wake out of STOP starts it
  smc_warmup #(
    .WARM_SHORT(WARM_SHORT),
    .WARM_LONG(WARM_LONG)
  ) u_warm (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(st_q.warmStart),
    .longSel(st_q.wsm[`SMC_BIT_WARM]),
    .done(warmDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] srcLevel(input smc_src_t s, input logic [2:0] l0);
    logic [2:0] r;
    r = 3'h0;
    case (s)
      SMC_SRC_NMI: r = `SMC_NMI_LEVEL;
      SMC_SRC_EXTERNAL_IRQ_ZERO_PIN: r = l0;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // wake decode, nmi ignores the mask
  always_comb begin
    hit = (paddr == `SMC_WSM_OFFSET);
    nmiWake = wake.rise[0];
    int0Wake = wake.rise[1];
    int0Unmasked = (interruptMaskLevel <= int0Level);
    // nmi wins when both pins rise together
    waker = nmiWake ? SMC_SRC_NMI : SMC_SRC_EXTERNAL_IRQ_ZERO_PIN;
    wakerLvl = srcLevel(waker, int0Level);
    pendLvl = srcLevel(st_q.pendSrc, int0Level);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d = st_q;
    st_d.warmStart = 1'b0;
    st_d.wakeService = 1'b0;
    st_d.wakeResume = 1'b0;
    // apb: answer one cycle after setup, zero wait states in access
    st_d.ready = 1'b0;
    st_d.err = 1'b0;
    if (psel && !penable) begin
      st_d.ready = 1'b1;
      st_d.err = !hit;
      st_d.rdata = hit ? {24'h000000, st_q.wsm} : 32'h00000000;
    end
    // the write lands only at the edge that sees pready high
    if (psel && penable && st_q.ready && pwrite && hit) begin
      st_d.wsm = pwdata[7:0];
    end
    // controller
    case (st_q.state)
      // running: a halt pulse picks the standby kind from the register
      SMC_ACTIVE: begin
        if (haltReq) begin
          st_d.mode = smc_mode_t'({st_q.wsm[`SMC_BIT_SEL_HI], st_q.wsm[`SMC_BIT_SEL_LO]});
          st_d.cpuRun = 1'b0;
          if (st_d.mode == SMC_MODE_RUN || st_d.mode == SMC_MODE_DC) begin
            st_d.state = SMC_RUN_HALT; // don't-care code falls back to RUN
          end else begin
            st_d.state = SMC_ENTER;
            st_d.entryCnt = `SMC_ENTRY_CYCLES;
          end
        end
      end
      SMC_ENTER: begin
        // a wake pin seen here cannot wake; hold it pending instead
        if (nmiWake || int0Wake) begin
          st_d.pendValid = 1'b1;
          st_d.pendSrc = nmiWake ? SMC_SRC_NMI : SMC_SRC_EXTERNAL_IRQ_ZERO_PIN;
        end
        // clocks stop only at the end of the window, so a late edge is held, not lost
        if (st_q.entryCnt == 2'd1) begin
          st_d.periphClkEn = 1'b0;
          st_d.sysClkEn = 1'b0;
          if (st_q.mode == SMC_MODE_STOP) begin
            st_d.oscEn = 1'b0;
            st_d.state = SMC_STOP_HALT;
            st_d.pinOutEn = st_q.wsm[`SMC_BIT_DRIVE];
            st_d.pinInGateEn = st_q.wsm[`SMC_BIT_DRIVE];
            st_d.oscOutForceHigh = 1'b1;
          end else begin
            st_d.state = SMC_IDLE_HALT;
          end
          st_d.aleForceLow = 1'b1;
        end else begin
          st_d.entryCnt = st_q.entryCnt - 2'd1;
        end
      end
      // core stopped, clocks on: an unmasked interrupt wins over the pins
      SMC_RUN_HALT: begin
        if (irqReq && interruptMaskLevel <= irqLevel) begin
          st_d.state = SMC_ACTIVE;
          st_d.cpuRun = 1'b1;
          st_d.wakeService = 1'b1;
          st_d.first = SMC_SRC_OTHER;
          st_d.second = SMC_SRC_NONE;
        end else if (nmiWake || (int0Wake && int0Unmasked)) begin
          st_d.state = SMC_ACTIVE;
          st_d.cpuRun = 1'b1;
          st_d.wakeService = 1'b1;
          st_d.first = waker;
          st_d.second = SMC_SRC_NONE;
        end else if (int0Wake) begin
          st_d.state = SMC_ACTIVE;
          st_d.cpuRun = 1'b1;
          st_d.wakeResume = 1'b1;
          st_d.first = SMC_SRC_NONE;
          st_d.second = SMC_SRC_NONE;
        end
      end
      SMC_IDLE_HALT, SMC_STOP_HALT: begin
        // only nmi or an unmasked external_irq_zero_pin wakes; other interrupts are ignored
        if (nmiWake || (int0Wake && int0Unmasked)) begin
          st_d.first = waker;
          st_d.second = SMC_SRC_NONE;
          if (st_q.pendValid) begin
            st_d.first = (pendLvl > wakerLvl) ? st_q.pendSrc : waker;
            st_d.second = (pendLvl > wakerLvl) ? waker : st_q.pendSrc;
            st_d.pendValid = 1'b0;
          end
          st_d.periphClkEn = 1'b1;
          st_d.aleForceLow = 1'b0;
          if (st_q.state == SMC_STOP_HALT) begin
            st_d.oscEn = 1'b1;
            st_d.oscOutForceHigh = 1'b0;
            st_d.pinOutEn = 1'b1;
            st_d.pinInGateEn = 1'b1;
            st_d.warmStart = 1'b1;
            st_d.state = SMC_WARMUP;
          end else begin
            st_d.sysClkEn = 1'b1;
            st_d.cpuRun = 1'b1;
            st_d.wakeService = 1'b1;
            st_d.state = SMC_ACTIVE;
          end
        end
      end
      SMC_WARMUP: begin
        // system clock stays off until the oscillator has settled
        if (warmDone) begin
          st_d.sysClkEn = 1'b1;
          st_d.cpuRun = 1'b1;
          st_d.wakeService = 1'b1;
          st_d.state = SMC_ACTIVE;
        end
      end
      // unused state codes recover to running
      default: begin
        st_d.state = SMC_ACTIVE;
      end
    endcase
    // pull choice: output function data, else port register only
    st_d.pullSel = pullFuncSel ? pullFuncData : pullPortBit;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; reset leaves standby at once with no warm-up count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      // reset also drops any request held from an entry window
      st_q.wsm <= `SMC_WSM_RESET;
      st_q.state <= SMC_ACTIVE;
      st_q.cpuRun <= 1'b1;
      st_q.periphClkEn <= 1'b1;
      st_q.oscEn <= 1'b1;
      st_q.sysClkEn <= 1'b1;
      st_q.pinOutEn <= 1'b1;
      st_q.pinInGateEn <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign cpuRun = st_q.cpuRun;
  assign periphClkEn = st_q.periphClkEn;
  assign oscEn = st_q.oscEn;
  assign sysClkEn = st_q.sysClkEn;
  assign wakeService = st_q.wakeService;
  assign wakeResume = st_q.wakeResume;
  assign serviceFirst = st_q.first;
  assign serviceSecond = st_q.second;
  assign pendValid = st_q.pendValid;
  assign pinOutEn = st_q.pinOutEn;
  assign pinInGateEn = st_q.pinInGateEn;
  assign aleForceLow = st_q.aleForceLow;
  assign oscOutForceHigh = st_q.oscOutForceHigh;
  assign pullSel = st_q.pullSel;
endmodule

// ### smc_standby_ctrl_asserts.sv
// Purpose: port-level checks of the standby control
// Assumes: one clock domain; reset active low
// Notes: warm-up bound allows one cycle of counter alignment
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_standby_ctrl_asserts
  import smc_pkg::*;
#(
  parameter logic [17:0] WARM_SHORT = `SMC_WARM_SHORT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // core and pins
  input wire logic haltReq,
  input wire logic irqReq,
  input wire logic [2:0] irqLevel,
  input wire logic [2:0] interruptMaskLevel,
  input wire logic nmiPin_n,
  input wire logic externalIrqZeroPin,
  // status
  input wire logic cpuRun,
  input wire logic periphClkEn,
  input wire logic oscEn,
  input wire logic sysClkEn,
  input wire logic wakeService,
  input wire logic wakeResume,
  input wire logic aleForceLow,
  input wire logic oscOutForceHigh
);
  logic [17:0] warmCnt_q; // cycles with oscillator up but system clock held
  ////////////////////////////////////////////////////////////////////////////////
  // warm-up counter; cleared whenever the system clock runs or the oscillator stops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      warmCnt_q <= '0;
    end else if (oscEn && !sysClkEn) begin
      warmCnt_q <= warmCnt_q + 18'd1;
    end else begin
      warmCnt_q <= '0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (psel && !penable |=> pready &&
    (pslverr == (paddr != `SMC_WSM_OFFSET))) else $error("apb answer wrong");
  halt_stops_a: assert property (haltReq && cpuRun && sysClkEn |=> !cpuRun)
    else $error("core not stopped by halt");
  stop_all_a: assert property (!oscEn |-> !sysClkEn && !periphClkEn && !cpuRun
    && oscOutForceHigh && aleForceLow) else $error("stop state incomplete");
  idle_core_a: assert property ($fell(periphClkEn) |-> !cpuRun && aleForceLow)
    else $error("peripherals stopped with core running");
  warm_count_a: assert property ($rose(sysClkEn) |-> warmCnt_q >= WARM_SHORT - 18'd1)
    else $error("system clock before warm-up");
  pin_sync_a: assert property ($rose(externalIrqZeroPin) && !oscEn |=> !oscEn [*2])
    else $error("wake pin used unsynchronised");
  run_wake_a: assert property (irqReq && !cpuRun && sysClkEn &&
    interruptMaskLevel <= irqLevel |=> wakeService) else $error("run wake missing");
  masked_hold_a: assert property (irqReq && !cpuRun && interruptMaskLevel > irqLevel
    && !externalIrqZeroPin && nmiPin_n |=> !wakeService) else $error("masked irq woke");
  deep_ignore_a: assert property (irqReq && !periphClkEn && nmiPin_n &&
    !externalIrqZeroPin |=> !wakeService && !wakeResume) else $error("irq woke deep");
endmodule

// ### smc_wake_if.sv
// Purpose: carries synchronised wake pin levels and edges
// Assumes: bit 0 is NMI (active high here), bit 1 is EXTERNAL_IRQ_ZERO_PIN
// Notes: driven by smc_pin_sync only
`timescale 1ns/100ps
interface smc_wake_if;
  logic [1:0] level; // filtered pin levels
  logic [1:0] rise; // one-cycle pulse on a confirmed rising level
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ### smc_warmup.sv
// Purpose: oscillator warm-up counter for leaving STOP
// Assumes: counts core_clk cycles, which stand for oscillator cycles
// Notes: counts are parameters so a simulation can shorten them
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_warmup
  import smc_pkg::*;
#(
  parameter logic [17:0] WARM_SHORT = `SMC_WARM_SHORT,
  parameter logic [17:0] WARM_LONG = `SMC_WARM_LONG
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic longSel,
  // status
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [17:0] cnt;
    logic done;
  } smc_warm_t;
  smc_warm_t st_q, st_d;

  ////////////////////////////////////////////////////////////////////////////////
  // load on start, pulse done when the interval has run out
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (start) begin
      st_d.busy = 1'b1;
      st_d.cnt = longSel ? WARM_LONG : WARM_SHORT;
    end else if (st_q.busy) begin
      if (st_q.cnt <= 18'd1) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 18'd1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule

// ### tb_top.sv
// Purpose: directed test of the standby control
// Assumes: warm-up counts shortened to 8 and 16
// Notes: inputs change by non-blocking assignment after rising edges
`timescale 1ns/100ps
`include "smc_regs.svh"
module tb_top
  import smc_pkg::*;
;
  localparam logic [11:0] A = `SMC_WSM_OFFSET;
  logic core_clk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, haltReq, rstn, er, s, r, irqReq = 1'b0;
  logic [2:0] irqLevel = 3'h3, interruptMaskLevel = 3'h0, int0Level = 3'h3;
  logic nmiPin_n = 1'b1, externalIrqZeroPin = 1'b0;
  logic pullFuncSel = 1'b0, pullFuncData = 1'b0, pullPortBit = 1'b0;
  logic cpuRun, periphClkEn, oscEn, sysClkEn, wakeService, wakeResume, pendValid;
  logic pinOutEn, pinInGateEn, aleForceLow, oscOutForceHigh, pullSel;
  smc_src_t serviceFirst, serviceSecond;
  int mismatches = 0, checked = 0, w;
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  smc_core_model CORE (.core_clk, .haltReq, .rstn);
  smc_standby_ctrl #(.WARM_SHORT(18'd8), .WARM_LONG(18'd16)) DUT (.core_clk, .rstn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .haltReq,
    .irqReq, .irqLevel, .interruptMaskLevel, .int0Level, .nmiPin_n, .externalIrqZeroPin,
    .pullFuncSel, .pullFuncData, .pullPortBit, .cpuRun, .periphClkEn, .oscEn, .sysClkEn,
    .wakeService, .wakeResume, .serviceFirst, .serviceSecond, .pendValid, .pinOutEn,
    .pinInGateEn, .aleForceLow, .oscOutForceHigh, .pullSel);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("counts: %0d checked, %0d wrong", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, m, g, e);
    end
  endtask
  // a wait that runs out ends the run as a failure
  task automatic timedOut();
    chk(1'b0, 1'b1, "wait ran out");
    complete_run();
  endtask
  // apb transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timedOut();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // wait for a wake pulse, counting warm-up cycles on the way
  task automatic wake();
    int n;
    n = 0;
    w = 0;
    while (wakeService !== 1'b1 && wakeResume !== 1'b1 && n < 300) begin
      if (oscEn === 1'b1 && sysClkEn !== 1'b1) w++;
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) timedOut();
    s = wakeService;
    r = wakeResume;
  endtask
  task automatic enter(input logic [7:0] v);
    apb(1'b1, A, {24'h0, v});
    CORE.halt();
    repeat (6) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE.reset(20);
    apb(1'b0, A, 32'h0);
    chk(rd, {24'h0, `SMC_WSM_RESET}, "reset value");
    apb(1'b0, 12'h060, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, A, 32'hFFFF_FFA5);
    apb(1'b0, A, 32'h0);
    chk(rd, 32'hA5, "readback");
    $display("test registers ended");
    irqReq <= 1'b1;
    interruptMaskLevel <= 3'h5;
    enter(8'h00);
    chk({cpuRun, periphClkEn, oscEn, sysClkEn}, 4'b0111, "run clocks");
    externalIrqZeroPin <= 1'b1;
    wake();
    chk({s, r}, 2'b01, "external_irq_zero_pin resume");
    externalIrqZeroPin <= 1'b0;
    enter(8'h00);
    interruptMaskLevel <= 3'h2; // unmask only once the core is halted
    wake();
    chk({s, r, serviceFirst}, {2'b10, SMC_SRC_OTHER}, "run service");
    irqReq <= 1'b0;
    interruptMaskLevel <= 3'h0;
    enter(8'h0C);
    chk({cpuRun, periphClkEn, oscEn, sysClkEn}, 4'b0111, "code 11 clocks");
    irqReq <= 1'b1;
    wake();
    chk(s, 1'b1, "code 11 wake");
    irqReq <= 1'b0;
    $display("test run ended");
    enter(8'h08);
    chk({cpuRun, periphClkEn, oscEn, sysClkEn}, 4'b0010, "idle clocks");
    irqReq <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(cpuRun, 1'b0, "idle ignores irq");
    irqReq <= 1'b0;
    nmiPin_n <= 1'b0;
    wake();
    chk({s, serviceFirst}, {1'b1, SMC_SRC_NMI}, "idle nmi wake");
    nmiPin_n <= 1'b1;
    $display("test idle ended");
    enter(8'h04);
    chk({cpuRun, periphClkEn, oscEn, sysClkEn, pinOutEn, pinInGateEn, aleForceLow,
      oscOutForceHigh}, 8'h03, "stop undriven");
    externalIrqZeroPin <= 1'b1;
    wake();
    chk({s, w >= 7 && w <= 11}, 2'b11, "short warm-up");
    externalIrqZeroPin <= 1'b0;
    enter(8'h15);
    chk({pinOutEn, pinInGateEn, oscEn}, 3'b110, "stop driven");
    externalIrqZeroPin <= 1'b1;
    wake();
    chk({s, w >= 15 && w <= 19}, 2'b11, "long warm-up");
    externalIrqZeroPin <= 1'b0;
    $display("test stop ended");
    int0Level <= 3'h2;
    apb(1'b1, A, 32'h04);
    nmiPin_n <= 1'b0; // synced edge lands inside the entry window
    repeat (2) @(posedge core_clk);
    CORE.halt();
    repeat (6) @(posedge core_clk);
    chk({pendValid, oscEn}, 2'b10, "held during entry");
    externalIrqZeroPin <= 1'b1;
    wake();
    chk({serviceFirst, serviceSecond}, {SMC_SRC_NMI, SMC_SRC_EXTERNAL_IRQ_ZERO_PIN}, "priority");
    nmiPin_n <= 1'b1;
    externalIrqZeroPin <= 1'b0;
    $display("test pending ended");
    enter(8'h04);
    CORE.reset(8);
    @(posedge core_clk);
    chk({cpuRun, oscEn, sysClkEn}, 3'b111, "reset exit");
    apb(1'b0, A, 32'h0);
    chk(rd, {24'h0, `SMC_WSM_RESET}, "value after reset");
    $display("test reset exit ended");
    for (int i = 0; i < 8; i++) begin
      {pullFuncSel, pullFuncData, pullPortBit} <= i[2:0];
      repeat (2) @(posedge core_clk);
      chk(pullSel, i[2] ? i[1] : i[0], "pull choice");
    end
    $display("test pull ended");
    complete_run();
  end
endmodule
bind smc_standby_ctrl smc_standby_ctrl_asserts #(.WARM_SHORT(WARM_SHORT)) u_chk (.core_clk,
  .rstn, .psel, .penable, .paddr, .pready, .pslverr, .haltReq, .irqReq, .irqLevel,
  .interruptMaskLevel, .nmiPin_n, .externalIrqZeroPin, .cpuRun, .periphClkEn, .oscEn,
  .sysClkEn, .wakeService, .wakeResume, .aleForceLow, .oscOutForceHigh);
